// ==== lrm_pkg.sv ====
// constants, layouts and types for the local/remote operating-mode selector
`default_nettype none
package lrm_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned END_SHOW_MS = 1000;
  localparam int unsigned END_SHOW_CYCLES = CLK_HZ / 1000 * END_SHOW_MS;
  localparam int unsigned SHOW_CNT_W = 26;

  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_MFFUNC = 8'h04;
  localparam logic [7:0] OFS_EDIT = 8'h08;
  localparam logic [7:0] OFS_ENTER = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_STORED = 8'h14;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // parameter table indices
  localparam logic [3:0] IDX_INIT = 4'h0;
  localparam logic [3:0] IDX_SOURCE = 4'h1;
  localparam logic [3:0] IDX_POLICY = 4'h2;
  localparam logic [3:0] IDX_VOLTAGE = 4'h3;
  localparam logic [3:0] IDX_PRESET_FIRST = 4'h4;
  localparam logic [3:0] IDX_PRESET_FOURTH = 4'h7;
  localparam logic [3:0] IDX_INCHING = 4'h8;

  localparam logic [15:0] INIT_RESTORE = 16'h0006;
  localparam logic [15:0] INIT_DONE_VALUE = 16'h0001;
  localparam logic [15:0] SOURCE_PANEL = 16'h0000;
  localparam logic [15:0] POLICY_RUN_AT_ONCE = 16'h0001;
  localparam logic [15:0] VOLT_200_CLASS = 16'h07d0;
  localparam logic [15:0] VOLT_400_CLASS = 16'h0fa0;

  localparam logic [3:0] MF_TWO_WIRE_REV = 4'h0;
  localparam logic [3:0] MF_THREE_WIRE_STOP = 4'h1;
  localparam logic [3:0] MF_MODE_SWITCH = 4'h5;
  localparam logic [19:0] MFFUNC_RESET = 20'hfffff;
  localparam logic [2:0] REF_SEL_INCHING = 3'h4;
  localparam logic [2:0] REF_SEL_RESET = 3'h0;

  typedef struct packed {
    logic mode_key;
    logic run_key;
    logic stop_key;
    logic enter_key;
    logic remote_run;
    logic [4:0] mf;
  } pin_in_s;

  typedef struct packed {
    logic remote;
    logic run;
    logic reverse;
    logic flash;
    logic end_show;
  } drive_out_s;

  typedef enum {INIT_IDLE, INIT_SHOW} init_e;

  function automatic logic [15:0] param_default(input logic [3:0] idx, input logic cls400);
    logic [15:0] v;
    v = 16'h0000;
    if (idx == IDX_INIT) begin
      v = INIT_DONE_VALUE;
    end else if (idx == IDX_VOLTAGE) begin
      v = cls400 ? VOLT_400_CLASS : VOLT_200_CLASS;
    end
    return v;
  endfunction : param_default
endpackage : lrm_pkg
`default_nettype wire

// ==== local_remote_mode_select.sv ====
// local/remote operating-mode selector with parameter table and axi4-lite registers
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
// Overview of operation
// (R1) The mode key, or any terminal set to function 5, toggles between Remote and Local.
// (R2) In Remote the run command and frequency come from the source chosen by source select.
// (R3) In Local only the panel run and stop keys and the panel frequency are used.
// (R4) After every power-up the mode is Remote.
// (R5) With source select at 0 both modes behave the same, using the panel.
// (R6) Frequencies entered from the panel go into one of four presets or the inching value.
// (R7) Terminals stay active in both modes, but functions 0 and 1 are ignored in Local.
// (R8) A run signal already present at a Local-to-Remote change is ignored until it drops.
// (R9) With the run policy at 1 a present run signal starts the drive on entering Remote.
// (R10) Confirming 6 in the init parameter restores every parameter to its default.
// (R11) After confirming init an end indication shows for about 1 s, then the value is 1.
// (R12) An unconfirmed edit that differs from the stored value flashes the display.
// (R13) Rated motor voltage defaults to 200.0 V or 400.0 V by unit class.
// (R14) Protected parameters cannot be changed while the drive is running; the code still lets a confirmed init restore reset them while running.
// (R15) The current mode is shown as a status indication.
module local_remote_mode_select
  import lrm_pkg::*;
#(
  parameter int unsigned SHOW_CYCLES = END_SHOW_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire pin_in_s pins,
  input wire logic class_400_strap,
  input wire logic [15:0] remote_freq,
  output drive_out_s drive,
  output logic [15:0] freq_ref,
  output logic [15:0] data_display
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  ////////////////////////////////////////////////////////////////////////////////////////
  // state
  logic [9:0] sync1, sync2, sync3, filt, filt_d;
  logic [9:0] next_filt;
  logic aw_held, w_held, next_aw_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic aw_bad, next_aw_bad;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [2:0] ref_sel, next_ref_sel;
  logic [19:0] mffunc, next_mffunc;
  logic [15:0] edit_value, next_edit_value;
  logic [3:0] edit_index, next_edit_index;
  logic [15:0] params [16];
  logic [15:0] next_params [16];
  logic run_latch, next_run_latch;
  logic run_ignore, next_run_ignore;
  logic rejected, next_rejected;
  logic strap_taken, next_strap_taken;
  logic class_400, next_class_400;
  init_e init_state, next_init_state;
  logic [SHOW_CNT_W-1:0] show_cnt, next_show_cnt;
  drive_out_s next_drive;
  logic [15:0] next_freq_ref, next_data_display;

  pin_in_s fp, fp_d;
  logic mode_pulse, run_pulse, stop_pulse, enter_key_pulse, mode_event;
  logic [4:0] mf_mode, mf_rev, mf_stop;
  logic wr_go, sw_enter, confirm, protect, panel_src, stop3w, want_reverse;
  logic [31:0] merged;

  assign fp = pin_in_s'(filt);
  assign fp_d = pin_in_s'(filt_d);

  ////////////////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_filt = (sync2 & sync3) | (filt & (sync2 | sync3));
    mode_pulse = fp.mode_key & ~fp_d.mode_key;
    run_pulse = fp.run_key & ~fp_d.run_key;
    stop_pulse = fp.stop_key & ~fp_d.stop_key;
    enter_key_pulse = fp.enter_key & ~fp_d.enter_key;
    for (int i = 0; i < 5; i++) begin
      mf_mode[i] = mffunc[i*4 +: 4] == MF_MODE_SWITCH;
      mf_rev[i] = mffunc[i*4 +: 4] == MF_TWO_WIRE_REV;
      mf_stop[i] = mffunc[i*4 +: 4] == MF_THREE_WIRE_STOP;
    end
    mode_event = mode_pulse | (|(fp.mf & ~fp_d.mf & mf_mode)); // R1

    // axi4-lite slave
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_aw_bad = aw_bad;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr[7:0];
      next_aw_bad = |s_axi_awaddr[31:8];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    wr_go = aw_held & w_held & ~s_axi_bvalid;
    sw_enter = 1'b0;
    merged = 32'h0;
    next_ref_sel = ref_sel;
    next_mffunc = mffunc;
    next_edit_value = edit_value;
    next_edit_index = edit_index;
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      if (aw_bad) begin
        next_bresp = RESP_SLVERR;
      end else if (aw_addr == OFS_CFG) begin
        merged = merge_bytes({29'h0, ref_sel}, w_data, w_strb);
        next_ref_sel = merged[2:0];
      end else if (aw_addr == OFS_MFFUNC) begin
        merged = merge_bytes({12'h0, mffunc}, w_data, w_strb);
        next_mffunc = merged[19:0];
      end else if (aw_addr == OFS_EDIT) begin
        merged = merge_bytes({12'h0, edit_index, edit_value}, w_data, w_strb);
        {next_edit_index, next_edit_value} = merged[19:0];
      end else if (aw_addr == OFS_ENTER) begin
        sw_enter = 1'b1;
      end else if (aw_addr != OFS_STATUS && aw_addr != OFS_STORED) begin
        next_bresp = RESP_SLVERR;
      end
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;

    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      next_rdata = 32'h0;
      if (|s_axi_araddr[31:8]) begin
        next_rresp = RESP_SLVERR;
      end else begin
        unique case (s_axi_araddr[7:0])
          OFS_CFG: next_rdata = {29'h0, ref_sel};
          OFS_MFFUNC: next_rdata = {12'h0, mffunc};
          OFS_EDIT: next_rdata = {12'h0, edit_index, edit_value};
          OFS_ENTER: next_rdata = 32'h0;
          OFS_STATUS: next_rdata = {24'h0, class_400, rejected, run_ignore, drive};  // R15
          OFS_STORED: next_rdata = {16'h0, params[edit_index]};
          default: next_rresp = RESP_SLVERR;
        endcase
      end
    end
    next_arready = ~next_rvalid;

    // strap caught once after reset release
    next_strap_taken = 1'b1;
    next_class_400 = strap_taken ? class_400 : class_400_strap;
    next_params = params;
    if (!strap_taken) begin
      next_params[IDX_VOLTAGE] = param_default(IDX_VOLTAGE, class_400_strap); // R13
    end

    // parameter editing and initialisation
    confirm = (sw_enter | enter_key_pulse) & (init_state == INIT_IDLE);
    protect = (edit_index == IDX_SOURCE) | (edit_index == IDX_VOLTAGE);
    next_rejected = rejected;
    next_init_state = init_state;
    next_show_cnt = show_cnt;
    if (confirm) begin
      if (protect && drive.run) begin
        next_rejected = 1'b1; // R14
      end else if (edit_index == IDX_INIT && edit_value == INIT_RESTORE) begin
        next_rejected = 1'b0;
        next_init_state = INIT_SHOW; // R11
        next_show_cnt = '0;
      end else begin
        next_rejected = 1'b0;
        next_params[edit_index] = edit_value; // R6 R12
      end
    end
    if (init_state == INIT_SHOW) begin
      next_show_cnt = show_cnt + 1'b1;
      if (show_cnt == SHOW_CNT_W'(SHOW_CYCLES - 1)) begin
        next_init_state = INIT_IDLE;
        for (int i = 0; i < 16; i++) begin
          next_params[i] = param_default(4'(i), class_400); // R10 R13
        end
        next_edit_index = IDX_INIT;
        next_edit_value = INIT_DONE_VALUE; // R11
      end
    end

    // mode and run command
    next_drive = drive;
    next_drive.remote = drive.remote ^ mode_event; // R1 R15
    panel_src = ~next_drive.remote | (params[IDX_SOURCE] == SOURCE_PANEL); // R3 R5
    stop3w = next_drive.remote & |(fp.mf & mf_stop); // R7
    want_reverse = next_drive.remote & |(fp.mf & mf_rev); // R7
    next_run_latch = run_latch;
    if (mode_event) begin
      next_run_latch = 1'b0;
    end else if (stop_pulse) begin
      next_run_latch = 1'b0;
    end else if (run_pulse) begin
      next_run_latch = 1'b1; // R3
    end
    next_run_ignore = run_ignore & fp.remote_run; // R8
    if (mode_event && next_drive.remote) begin
      // policy 1 also drops an ignore still armed from an earlier entry
      next_run_ignore = (params[IDX_POLICY] != POLICY_RUN_AT_ONCE) & fp.remote_run; // R8 R9
    end
    if (panel_src) begin
      next_drive.run = next_run_latch;
      next_drive.reverse = 1'b0;
      if (ref_sel <= REF_SEL_INCHING) begin
        next_freq_ref = params[IDX_PRESET_FIRST + {1'b0, ref_sel}]; // R6
      end else begin
        next_freq_ref = params[IDX_PRESET_FIRST];
      end
    end else begin
      next_drive.run = fp.remote_run & ~next_run_ignore & ~stop3w; // R2 R8 R9
      next_drive.reverse = want_reverse;
      next_freq_ref = remote_freq; // R2
    end
    next_drive.end_show = next_init_state == INIT_SHOW; // R11
    next_drive.flash = next_edit_value != next_params[next_edit_index]; // R12
    next_data_display = next_drive.end_show ? params[IDX_INIT] : next_edit_value;
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge aclk) begin
    sync1 <= pins;
    sync2 <= sync1;
    sync3 <= sync2;
    params <= next_params;
    if (!aresetn) begin
      filt <= '0;
      filt_d <= '0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      aw_bad <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      ref_sel <= REF_SEL_RESET;
      mffunc <= MFFUNC_RESET;
      edit_value <= INIT_DONE_VALUE;
      edit_index <= IDX_INIT;
      for (int i = 0; i < 16; i++) begin
        params[i] <= param_default(4'(i), 1'b0);
      end
      run_latch <= 1'b0;
      run_ignore <= 1'b0;
      rejected <= 1'b0;
      strap_taken <= 1'b0;
      class_400 <= 1'b0;
      init_state <= INIT_IDLE;
      show_cnt <= '0;
      drive <= '{remote: 1'b1, default: 1'b0}; // R4
      freq_ref <= 16'h0000;
      data_display <= INIT_DONE_VALUE;
    end else begin
      filt <= next_filt;
      filt_d <= filt;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      aw_bad <= next_aw_bad;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      ref_sel <= next_ref_sel;
      mffunc <= next_mffunc;
      edit_value <= next_edit_value;
      edit_index <= next_edit_index;
      run_latch <= next_run_latch;
      run_ignore <= next_run_ignore;
      rejected <= next_rejected;
      strap_taken <= next_strap_taken;
      class_400 <= next_class_400;
      init_state <= next_init_state;
      show_cnt <= next_show_cnt;
      drive <= next_drive;
      freq_ref <= next_freq_ref;
      data_display <= next_data_display;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  // checks
  power_up_remote_a: assert property (@(posedge aclk) // R4
    $rose(aresetn) |-> drive.remote)
    else $error("mode not remote after reset");

  mode_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
    mode_event |=> drive.remote != $past(drive.remote))
    else $error("mode did not toggle");

  local_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn) // R7
    !drive.remote |-> !drive.reverse)
    else $error("reverse taken in local mode");

  run_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    (mode_event && !drive.remote && fp.remote_run && params[IDX_POLICY] != POLICY_RUN_AT_ONCE
     && params[IDX_SOURCE] != SOURCE_PANEL) |=> !drive.run [*2])
    else $error("held run not ignored on entering remote");

  policy_run_a: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    (mode_event && !drive.remote && fp.remote_run && !stop3w
     && params[IDX_POLICY] == POLICY_RUN_AT_ONCE && params[IDX_SOURCE] != SOURCE_PANEL)
    |=> drive.run)
    else $error("run policy did not start drive");

  init_show_a: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    (confirm && !(protect && drive.run) && edit_index == IDX_INIT && edit_value == INIT_RESTORE)
    |=> drive.end_show [*2])
    else $error("end indication missing");

  init_restore_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
    $fell(drive.end_show) |-> params[IDX_INIT] == INIT_DONE_VALUE
      && params[IDX_PRESET_FIRST] == 16'h0000 && data_display == INIT_DONE_VALUE)
    else $error("parameters not restored");

  reject_run_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
    (confirm && protect && drive.run) |=> rejected && $stable(params[edit_index]))
    else $error("protected change accepted while running");

  flash_clear_a: assert property (@(posedge aclk) disable iff (!aresetn) // R12
    (confirm && !protect && edit_index != IDX_INIT) |=> !drive.flash)
    else $error("display still flashing after confirm");

  voltage_default_a: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    $rose(strap_taken) |-> params[IDX_VOLTAGE] == ($past(class_400_strap) ? VOLT_400_CLASS
                                                                           : VOLT_200_CLASS))
    else $error("wrong rated voltage default");
endmodule : local_remote_mode_select
`default_nettype wire

// ==== panel_model.sv ====
// keypad and higher-level controller model driving the selector's pins
`default_nettype none
module panel_model
  import lrm_pkg::*;
(
  input wire logic aclk,
  output var pin_in_s pins,
  output var logic [15:0] remote_freq
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] REMOTE_REF = 16'h0abc;
  initial begin
    pins = '0;
    remote_freq = REMOTE_REF;
  end
  // one pin changes level, held long enough to pass the input filter
  task automatic set_pin(input int unsigned i, input logic v);
    @(posedge aclk);
    pins[i] <= v;
    repeat (8) @(posedge aclk);
  endtask : set_pin
  task automatic tap(input int unsigned i);
    set_pin(i, 1'b1);
    set_pin(i, 1'b0);
  endtask : tap
  // controller drops its run level and raises it again after a mode change
  task automatic rerun();
    set_pin(5, 1'b0);
    set_pin(5, 1'b1);
  endtask : rerun
endmodule : panel_model
`default_nettype wire

// ==== test_local_remote_mode_select.sv ====
// self-checking testbench for the local/remote mode selector
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module test_local_remote_mode_select
  import lrm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHOW = 8;
  localparam int LIMIT = 20000;
  localparam int K_MODE = 9;
  localparam int K_RUN = 8;
  localparam int K_STOP = 7;
  localparam int K_RRUN = 5;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic strap = 1'b0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [15:0] freq_ref, disp, remote_freq;
  pin_in_s pins;
  drive_out_s drive;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  always #10 aclk = ~aclk;

  local_remote_mode_select #(.SHOW_CYCLES(SHOW)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pins(pins), .class_400_strap(strap), .remote_freq(remote_freq),
    .drive(drive), .freq_ref(freq_ref), .data_display(disp)
  );
  panel_model u_panel (.aclk(aclk), .pins(pins), .remote_freq(remote_freq));

  ////////////////////////////////////////
  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic set_param(input logic [3:0] idx, input logic [15:0] v);
    axi_wr({24'h0, OFS_EDIT}, {12'h000, idx, v});
    axi_wr({24'h0, OFS_ENTER}, 32'h0);
    repeat (2) @(posedge aclk);
  endtask : set_param

  task automatic read_param(input logic [3:0] idx);
    axi_wr({24'h0, OFS_EDIT}, {12'h000, idx, 16'h0000});
    axi_rd({24'h0, OFS_STORED});
  endtask : read_param

  task automatic do_reset(input logic cls);
    aresetn <= 1'b0;
    strap <= cls;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask : do_reset

  ////////////////////////////////////////
  task automatic t_power();
    do_reset(1'b1);
    `CHK(drive.remote, 1'b1);
    read_param(IDX_VOLTAGE);
    `CHK(rd[15:0], 16'd4000);
    u_panel.tap(K_MODE);
    `CHK(drive.remote, 1'b0);
    axi_rd({24'h0, OFS_STATUS});
    `CHK(rd[4], 1'b0);
    do_reset(1'b0);
    `CHK(drive.remote, 1'b1);
    axi_rd({24'h0, OFS_STATUS});
    `CHK(rd[4], 1'b1);
    read_param(IDX_VOLTAGE);
    `CHK(rd[15:0], 16'd2000);
  endtask : t_power

  task automatic t_local();
    u_panel.tap(K_MODE);
    for (int i = 0; i < 5; i++) begin
      axi_wr({24'h0, OFS_CFG}, 32'(i));
      set_param(4'(IDX_PRESET_FIRST + 4'(i)), 16'h0100 + 16'(i));
      `CHK(freq_ref, 16'h0100 + 16'(i));
    end
    axi_wr({24'h0, OFS_MFFUNC}, 32'h000ff1ff);
    u_panel.set_pin(2, 1'b1);
    u_panel.set_pin(K_RRUN, 1'b1);
    `CHK(drive.run, 1'b0);
    u_panel.tap(K_RUN);
    `CHK(drive.run, 1'b1);
    u_panel.tap(K_STOP);
    `CHK(drive.run, 1'b0);
    u_panel.set_pin(2, 1'b0);
  endtask : t_local

  task automatic t_switch();
    set_param(IDX_SOURCE, 16'h0001);
    axi_wr({24'h0, OFS_MFFUNC}, 32'h000fff05);
    u_panel.set_pin(1, 1'b1);
    `CHK(drive.reverse, 1'b0);
    u_panel.tap(0);
    `CHK(drive.remote, 1'b1);
    `CHK(drive.run, 1'b0);
    `CHK(freq_ref, remote_freq);
    u_panel.rerun();
    `CHK(drive.run, 1'b1);
    `CHK(drive.reverse, 1'b1);
    set_param(IDX_SOURCE, 16'h0000);
    axi_rd({24'h0, OFS_STATUS});
    `CHK(rd[6], 1'b1);
    read_param(IDX_SOURCE);
    `CHK(rd[15:0], 16'h0001);
    u_panel.set_pin(K_RRUN, 1'b0);
    `CHK(drive.run, 1'b0);
    set_param(IDX_POLICY, POLICY_RUN_AT_ONCE);
    u_panel.tap(0);
    `CHK(drive.remote, 1'b0);
    u_panel.set_pin(K_RRUN, 1'b1);
    u_panel.tap(0);
    `CHK(drive.run, 1'b1);
    u_panel.set_pin(K_RRUN, 1'b0);
    u_panel.set_pin(1, 1'b0);
    set_param(IDX_SOURCE, 16'h0000);
    u_panel.tap(K_RUN);
    `CHK(drive.run, 1'b1);
    `CHK(freq_ref, 16'h0104);
    u_panel.tap(K_STOP);
  endtask : t_switch

  task automatic t_init();
    axi_wr({24'h0, OFS_EDIT}, {12'h000, IDX_INIT, 16'h0006});
    repeat (2) @(posedge aclk);
    `CHK(drive.flash, 1'b1);
    axi_wr({24'h0, OFS_ENTER}, 32'h0);
    `CHK(drive.end_show, 1'b1);
    repeat (SHOW - 3) @(posedge aclk);
    `CHK(drive.end_show, 1'b1);
    repeat (7) @(posedge aclk);
    `CHK(drive.end_show, 1'b0);
    `CHK(drive.flash, 1'b0);
    `CHK(disp, 16'h0001);
    read_param(IDX_PRESET_FIRST);
    `CHK(rd[15:0], 16'h0000);
    read_param(IDX_POLICY);
    `CHK(rd[15:0], 16'h0000);
  endtask : t_init

  task automatic t_bus();
    axi_wr(32'h0000_0018, 32'h0);
    `CHK(rs, RESP_SLVERR);
    axi_rd(32'h0000_0100);
    `CHK(rs, RESP_SLVERR);
    `CHK(rd, 32'h0);
    axi_wr({24'h0, OFS_STATUS}, 32'hffff_ffff);
    `CHK(rs, RESP_OKAY);
    axi_rd({24'h0, OFS_CFG});
    `CHK(rd[2:0], 3'h4);
  endtask : t_bus

  initial begin
    t_power();
    t_local();
    t_switch();
    t_init();
    t_bus();
    end_of_test();
  end
endmodule : test_local_remote_mode_select
`default_nettype wire
